// >>> logic/slcr_regs.sv
`timescale 1ns/1ps
module slcr_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port from local or remote control access
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // other registers of the device, held elsewhere
  input wire logic [7:0] i_own_addr,
  input wire logic [6:0] i_des_alias,
  input wire logic [6:0] i_slave_id,
  input wire logic [6:0] i_slave_alias,
  // back channel address load
  input wire logic i_rx_lock,
  input wire logic i_bc_load,
  input wire logic [6:0] i_bc_addr,
  // incoming i2c access target
  input wire logic i_acc_valid,
  input wire logic [6:0] i_acc_addr,
  input wire logic i_acc_write,
  // forwarding decision
  output logic o_fwd,
  output logic [6:0] o_fwd_addr,
  output logic o_auto_ack,
  // datapath controls
  output logic o_crc_chk_en,
  output logic o_parity_en,
  output logic o_crc_clear,
  output logic o_sample_edge_select
);
  logic [7:0] gen_cfg_r;
  logic [6:0] remote_deser_address_r;
  logic freeze_r;
  logic [6:0] own7;
  logic pass_thru, pass_all, hit_des, hit_slave, fwd_nxt;
  logic [6:0] fwd_addr_nxt;

  // alias match, a zero field never matches
  function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] f);
    return (f != 7'h00) && (a == f);
  endfunction

  // general configuration register, every bit stored as written
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gen_cfg_r <= slcr_pkg::GEN_CFG_RST;
    end else if (i_wr_en && i_addr == slcr_pkg::GEN_CFG_OFS) begin
      gen_cfg_r <= i_wdata;
    end
  end

  // freeze bit only changes by software
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      freeze_r <= slcr_pkg::REMOTE_DESER_ADDRESS_RST[slcr_pkg::FREEZE_BIT];
    end else if (i_wr_en && i_addr == slcr_pkg::REMOTE_DESER_ADDRESS_OFS) begin
      freeze_r <= i_wdata[slcr_pkg::FREEZE_BIT];
    end
  end

  // remote address: software write beats a back-channel load in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      remote_deser_address_r <= slcr_pkg::REMOTE_DESER_ADDRESS_RST[slcr_pkg::ADDR_MSB:slcr_pkg::ADDR_LSB];
    end else if (i_wr_en && i_addr == slcr_pkg::REMOTE_DESER_ADDRESS_OFS) begin
      remote_deser_address_r <= i_wdata[slcr_pkg::ADDR_MSB:slcr_pkg::ADDR_LSB];
    end else if (i_rx_lock && i_bc_load && !freeze_r) begin
      remote_deser_address_r <= i_bc_addr;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    o_rdata = 8'h00;
    case (i_addr)
      slcr_pkg::GEN_CFG_OFS: o_rdata = gen_cfg_r;
      slcr_pkg::REMOTE_DESER_ADDRESS_OFS: o_rdata = {remote_deser_address_r, freeze_r};
      default: o_rdata = 8'h00;
    endcase
  end

  // control outputs straight from flops
  assign o_crc_chk_en = gen_cfg_r[slcr_pkg::CRC_CHK_EN_BIT];
  assign o_parity_en = gen_cfg_r[slcr_pkg::PARITY_EN_BIT];
  assign o_crc_clear = gen_cfg_r[slcr_pkg::CRC_CLR_BIT];
  assign o_sample_edge_select = gen_cfg_r[slcr_pkg::SAMPLE_EDGE_BIT];

  // forwarding decision for the incoming access
  assign own7 = i_own_addr[slcr_pkg::ADDR_MSB:slcr_pkg::ADDR_LSB];
  assign pass_thru = gen_cfg_r[slcr_pkg::PASS_THRU_BIT];
  assign pass_all = gen_cfg_r[slcr_pkg::PASS_ALL_BIT];
  // a zero remote address blocks the deserializer path entirely
  assign hit_des = addr_hit(i_acc_addr, i_des_alias) && (remote_deser_address_r != 7'h00);
  assign hit_slave = addr_hit(i_acc_addr, i_slave_alias) && (i_slave_id != 7'h00);

  always_comb begin
    fwd_nxt = 1'b0;
    fwd_addr_nxt = 7'h00;
    if (i_acc_valid && pass_thru) begin
      if (hit_des) begin
        fwd_nxt = 1'b1;
        fwd_addr_nxt = remote_deser_address_r;
      end else if (hit_slave) begin
        fwd_nxt = 1'b1;
        fwd_addr_nxt = i_slave_id;
      end else if (pass_all && i_acc_addr != own7 && remote_deser_address_r != 7'h00) begin
        fwd_nxt = 1'b1;
        fwd_addr_nxt = remote_deser_address_r;
      end
    end
  end

  // registered decision, one cycle after the access is presented
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fwd <= 1'b0;
      o_fwd_addr <= 7'h00;
      o_auto_ack <= 1'b0;
    end else begin
      o_fwd <= fwd_nxt;
      o_fwd_addr <= fwd_addr_nxt;
      // is the host's duty: ack is given without checking lock
      o_auto_ack <= fwd_nxt && i_acc_write && gen_cfg_r[slcr_pkg::AUTO_ACK_BIT];
    end
  end

  // checks; write strobes kept as plain flags since a sequence cannot be negated in an antecedent
  logic des_wr;
  logic cfg_wr;
  assign des_wr = i_wr_en && (i_addr == slcr_pkg::REMOTE_DESER_ADDRESS_OFS);
  assign cfg_wr = i_wr_en && (i_addr == slcr_pkg::GEN_CFG_OFS);
  sequence s_des_write;
    des_wr;
  endsequence
  sequence s_cfg_write;
    cfg_wr;
  endsequence
  property p_reset_value;
    @(posedge i_clk) $fell(i_rst) |->
      gen_cfg_r == slcr_pkg::GEN_CFG_RST && {remote_deser_address_r, freeze_r} == slcr_pkg::REMOTE_DESER_ADDRESS_RST;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("config reset value wrong");
  property p_crc_hold;
    @(posedge i_clk) disable iff (i_rst)
      o_crc_clear && !(i_wr_en && i_addr == slcr_pkg::GEN_CFG_OFS) |=> o_crc_clear;
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc clear dropped by itself");
  property p_no_fwd_off;
    @(posedge i_clk) disable iff (i_rst) !pass_thru |=> !o_fwd;
  endproperty
  a_no_fwd_off: assert property (p_no_fwd_off) else $error("forward while pass-through off");
  property p_freeze;
    @(posedge i_clk) disable iff (i_rst)
      freeze_r && !des_wr |=> $stable(remote_deser_address_r);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen address changed");
  property p_load;
    @(posedge i_clk) disable iff (i_rst)
      i_rx_lock && i_bc_load && !freeze_r && !des_wr |=> remote_deser_address_r == $past(i_bc_addr);
  endproperty
  a_load: assert property (p_load) else $error("back channel load missed");
  property p_zero_block;
    @(posedge i_clk) disable iff (i_rst) o_fwd |-> o_fwd_addr != 7'h00;
  endproperty
  a_zero_block: assert property (p_zero_block) else $error("forward to zero address");
  property p_auto_ack;
    @(posedge i_clk) disable iff (i_rst) o_auto_ack |-> o_fwd && $past(gen_cfg_r[slcr_pkg::AUTO_ACK_BIT]);
  endproperty
  a_auto_ack: assert property (p_auto_ack) else $error("auto ack without enable");
  property p_own_addr;
    @(posedge i_clk) disable iff (i_rst)
      i_acc_valid && i_acc_addr == own7 && !hit_des && !hit_slave |=> !o_fwd;
  endproperty
  a_own_addr: assert property (p_own_addr) else $error("own address forwarded");
  property p_alias_remap;
    @(posedge i_clk) disable iff (i_rst)
      i_acc_valid && pass_thru && hit_des |=> o_fwd && o_fwd_addr == $past(remote_deser_address_r);
  endproperty
  a_alias_remap: assert property (p_alias_remap) else $error("alias not remapped");
  // software writes land whole, reserved bit included
  property p_cfg_write;
    @(posedge i_clk) disable iff (i_rst) s_cfg_write |=> gen_cfg_r == $past(i_wdata);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
  property p_des_write;
    @(posedge i_clk) disable iff (i_rst) s_des_write |=> {remote_deser_address_r, freeze_r} == $past(i_wdata);
  endproperty
  a_des_write: assert property (p_des_write) else $error("remote address write lost");
  // auto ack must really fire, not only stay away when disabled
  property p_ack_given;
    @(posedge i_clk) disable iff (i_rst)
      i_acc_valid && i_acc_write && pass_thru && hit_des && gen_cfg_r[slcr_pkg::AUTO_ACK_BIT] |=> o_auto_ack;
  endproperty
  a_ack_given: assert property (p_ack_given) else $error("auto ack missing");
  property p_ack_read;
    @(posedge i_clk) disable iff (i_rst) i_acc_valid && !i_acc_write |=> !o_auto_ack;
  endproperty
  a_ack_read: assert property (p_ack_read) else $error("auto ack on a read");
  property p_no_match;
    @(posedge i_clk) disable iff (i_rst) i_acc_valid && !pass_all && !hit_des && !hit_slave |=> !o_fwd;
  endproperty
  a_no_match: assert property (p_no_match) else $error("unmatched access forwarded");
  property p_pass_all_remap;
    @(posedge i_clk) disable iff (i_rst)
      i_acc_valid && pass_thru && pass_all && !hit_des && !hit_slave && i_acc_addr != own7
        && remote_deser_address_r != 7'h00 |=> o_fwd && o_fwd_addr == $past(remote_deser_address_r);
  endproperty
  a_pass_all_remap: assert property (p_pass_all_remap) else $error("pass-all target not remapped");
endmodule // slcr_regs

// >>> logic/slcr_pkg.sv
package slcr_pkg;
  // register offsets on the local register port
  localparam logic [7:0] GEN_CFG_OFS = 8'h03;
  localparam logic [7:0] REMOTE_DESER_ADDRESS_OFS = 8'h06;
  localparam logic [7:0] DES_ALIAS_OFS = 8'h07;
  localparam logic [7:0] SLAVE_ID_OFS = 8'h08;
  localparam logic [7:0] SLAVE_ALIAS_OFS = 8'h09;
  // values after reset
  localparam logic [7:0] GEN_CFG_RST = 8'hC5;
  localparam logic [7:0] REMOTE_DESER_ADDRESS_RST = 8'h00;
  // general configuration bit positions
  localparam int CRC_CHK_EN_BIT = 7;
  localparam int PARITY_EN_BIT = 6;
  localparam int CRC_CLR_BIT = 5;
  localparam int AUTO_ACK_BIT = 4;
  localparam int PASS_ALL_BIT = 3;
  localparam int PASS_THRU_BIT = 2;
  localparam int SAMPLE_EDGE_BIT = 0;
  // remote address register field positions
  localparam int FREEZE_BIT = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
endpackage

// >>> tb/slcr_far_end.sv
`timescale 1ns/1ps
module slcr_far_end (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // request for one back-channel address load
  input wire logic i_go,
  input wire logic [6:0] i_addr,
  // back channel toward the registers
  output logic o_rx_lock,
  output logic o_bc_load,
  output logic [6:0] o_bc_addr
);
  // lock rises with the first load and stays; stale address toggles so it never looks valid
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_lock <= 1'b0;
      o_bc_load <= 1'b0;
      o_bc_addr <= 7'h00;
    end else begin
      o_rx_lock <= o_rx_lock | i_go;
      o_bc_load <= i_go;
      o_bc_addr <= i_go ? i_addr : ~o_bc_addr;
    end
  end
endmodule // slcr_far_end

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0, i_rst = 1'b1, i_wr_en = 1'b0, i_acc_valid = 1'b0, i_acc_write = 1'b0, go = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [6:0] i_acc_addr = 7'h00, bc_in = 7'h00, o_fwd_addr, bc_addr;
  logic o_fwd, o_auto_ack, o_crc_chk_en, o_parity_en, o_crc_clear, o_sample_edge_select, rx_lock, bc_load;
  logic [3:0] ctl;
  int n_fail = 0, compares = 0;
  // datapath controls gathered for one compare
  assign ctl = {o_crc_chk_en, o_parity_en, o_crc_clear, o_sample_edge_select};
  always #2.5 i_clk = ~i_clk;
  slcr_regs DUT (.i_clk, .i_rst, .i_wr_en, .i_addr, .i_wdata, .o_rdata, .i_own_addr(8'hB0),
    .i_des_alias(7'h40), .i_slave_id(7'h31), .i_slave_alias(7'h41), .i_rx_lock(rx_lock),
    .i_bc_load(bc_load), .i_bc_addr(bc_addr), .i_acc_valid, .i_acc_addr, .i_acc_write, .o_fwd,
    .o_fwd_addr, .o_auto_ack, .o_crc_chk_en, .o_parity_en, .o_crc_clear, .o_sample_edge_select);
  slcr_far_end FAR (.i_clk, .i_rst, .i_go(go), .i_addr(bc_in), .o_rx_lock(rx_lock),
    .o_bc_load(bc_load), .o_bc_addr(bc_addr));
  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // each bus task waits an edge first, so a strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1 {i_wr_en, i_addr, i_wdata} = {1'b1, a, d};
    @(posedge i_clk) #1 i_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk) #1 i_addr = a;
    #1 chk({1'b0, o_rdata}, {1'b0, e});
  endtask
  // answer lands one cycle after the access; target only matters when forwarded
  task automatic acc(input logic [6:0] a, input logic w, input logic [8:0] e);
    @(posedge i_clk) #1 {i_acc_valid, i_acc_addr, i_acc_write} = {1'b1, a, w};
    @(posedge i_clk) #1 i_acc_valid = 1'b0;
    chk({o_fwd, o_auto_ack, o_fwd ? o_fwd_addr : 7'h00}, e);
  endtask
  task automatic bc(input logic [6:0] a);
    @(posedge i_clk) #1 {go, bc_in} = {1'b1, a};
    @(posedge i_clk) #1 go = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    #1 i_rst = 1'b0;
    rd(8'h03, 8'hC5);
    chk({5'h00, ctl}, 9'h00D);
    rd(8'h06, 8'h00);
    rd(8'h04, 8'h00);
    $display("test 1 done");
    wr(8'h03, 8'h22);
    wr(8'h05, 8'hFF);
    rd(8'h03, 8'h22);
    rd(8'h05, 8'h00);
    repeat (20) @(posedge i_clk);
    chk({5'h00, ctl}, 9'h002);
    $display("test 2 done");
    bc(7'h2A);
    rd(8'h06, 8'h54);
    acc(7'h40, 1'b1, 9'h000);
    $display("test 3 done");
    wr(8'h03, 8'h14);
    acc(7'h40, 1'b1, 9'h1AA);
    acc(7'h40, 1'b0, 9'h12A);
    acc(7'h41, 1'b0, 9'h131);
    acc(7'h33, 1'b1, 9'h000);
    $display("test 4 done");
    wr(8'h03, 8'h0C);
    acc(7'h33, 1'b1, 9'h12A);
    acc(7'h58, 1'b1, 9'h000);
    wr(8'h03, 8'h1C);
    acc(7'h33, 1'b1, 9'h1AA);
    acc(7'h33, 1'b0, 9'h12A);
    $display("test 5 done");
    wr(8'h06, 8'h23);
    bc(7'h55);
    rd(8'h06, 8'h23);
    wr(8'h06, 8'h00);
    acc(7'h40, 1'b1, 9'h000);
    acc(7'h33, 1'b1, 9'h000);
    $display("test 6 done");
    // reset in mid-run must bring back the values after reset
    @(posedge i_clk) #1 i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_rst = 1'b0;
    rd(8'h03, 8'hC5);
    rd(8'h06, 8'h00);
    $display("test 7 done");
    wrap_up();
  end
endmodule // tb_top
